/* File: design/sdci_pkg.sv */
// Package of constants for the step/direction command input block
package sdci_pkg;
	// ************************************************************
	// Register map (APB byte addresses)
	// ************************************************************
	localparam logic [11:0] SDCI_CTRL_OFS   = 12'h000;
	localparam logic [11:0] SDCI_STATUS_OFS = 12'h004;
	localparam logic [11:0] SDCI_POS_OFS    = 12'h008;
	localparam logic [11:0] SDCI_COUNT_OFS  = 12'h00c;

	// ************************************************************
	// Control field positions and reset values
	// ************************************************************
	localparam int          SDCI_CTRL_MODE_BIT = 0;
	localparam int          SDCI_CTRL_EDGE_BIT = 1;
	localparam int          SDCI_CTRL_CLR_BIT  = 2;
	localparam logic [31:0] SDCI_CTRL_RESET    = 32'h0000_0000;

	// ************************************************************
	// Status field positions
	// ************************************************************
	localparam int SDCI_ST_EN_BIT   = 0;
	localparam int SDCI_ST_DIR_BIT  = 1;
	localparam int SDCI_ST_STEP_BIT = 2;
	localparam int SDCI_ST_REV_BIT  = 3;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_PERIOD_NS     = 100;
	localparam int PULSE_MIN_NS      = 7500;
	localparam int DIR_SETUP_NS      = 5000;
	localparam int PULSE_MIN_CYC     = (PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DIR_SETUP_CYC     = (DIR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SYNC_STAGES       = 2;

	// ************************************************************
	// Width of position (step count is 16 bits)
	// ************************************************************
	localparam int POS_W = 32;
endpackage

/* File: design/sdci_sync.sv */
// Two-stage synchroniser with registered edge detection for one input
`timescale 1ns/1ps
module sdci_sync (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic reset_level,
	input  wire logic async_in,
	output logic      level_out,
	output logic      rise_out,
	output logic      fall_out
);
	import sdci_pkg::*;

	logic meta_reg;
	logic sync_reg;
	logic prev_reg;

	// First stage feeds only the second; edges come from stages two and three
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	assign level_out = sync_reg;
	assign rise_out  = sync_reg & ~prev_reg;
	assign fall_out  = ~sync_reg & prev_reg;

	// Unused here, kept so one reset level can be chosen per instance later
	logic unused_reset_level;
	assign unused_reset_level = reset_level;
endmodule

/* File: design/sdci_top.sv */
// Step/direction command input front end with APB register access
`timescale 1ns/1ps
module sdci_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        step_pulse_in,
	input  wire logic        dir_in,
	input  wire logic        drive_enable_in,
	output logic             step_advance,
	output logic             step_dir_ccw,
	output logic             drive_enabled
);
	import sdci_pkg::*;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic step_lvl;
	logic step_rise;
	logic step_fall;
	logic dir_lvl;
	logic dir_rise;
	logic dir_fall;
	logic en_lvl;

	sdci_sync u_sync_step (
		.pclk        (pclk),
		.presetn     (presetn),
		.reset_level (1'b0),
		.async_in    (step_pulse_in),
		.level_out   (step_lvl),
		.rise_out    (step_rise),
		.fall_out    (step_fall)
	);

	sdci_sync u_sync_dir (
		.pclk        (pclk),
		.presetn     (presetn),
		.reset_level (1'b0),
		.async_in    (dir_in),
		.level_out   (dir_lvl),
		.rise_out    (dir_rise),
		.fall_out    (dir_fall)
	);

	// An open enable pin is pulled high at the pad, so it reads as enabled
	sdci_sync u_sync_en (
		.pclk        (pclk),
		.presetn     (presetn),
		.reset_level (1'b1),
		.async_in    (drive_enable_in),
		.level_out   (en_lvl),
		.rise_out    (),
		.fall_out    ()
	);

	// ************************************************************
	// Control register and internal state
	// ************************************************************
	logic [31:0]      ctrl_reg;
	logic [POS_W-1:0] pos_reg;
	logic [POS_W-1:0] pos_next;
	logic [15:0]      count_reg;
	logic [7:0]       high_cnt_reg;
	logic             short_pulse_reg;
	logic             step_advance_reg;
	logic             step_dir_ccw_reg;
	logic             drive_enabled_reg;

	wire mode_dual  = ctrl_reg[SDCI_CTRL_MODE_BIT];
	wire edge_fall  = ctrl_reg[SDCI_CTRL_EDGE_BIT];

	// ************************************************************
	// Step event decode
	// ************************************************************

	// Step/direction: chosen edge of step input; direction from level
	wire sd_event   = ~mode_dual & (edge_fall ? step_fall : step_rise);
	wire sd_ccw     = dir_lvl;
	// Dual pulse: active edge of each input gives its own direction
	wire cw_event   = mode_dual & (edge_fall ? step_fall : step_rise);
	wire ccw_event  = mode_dual & (edge_fall ? dir_fall : dir_rise);
	// Both dual-pulse inputs in one cycle cancel; no net motion
	wire any_event  = sd_event | (cw_event ^ ccw_event);
	wire ev_ccw     = mode_dual ? ccw_event : sd_ccw;
	wire accept     = any_event & en_lvl;

	// ************************************************************
	// Position and step count
	// ************************************************************

	// Position wraps silently; software reads it as a signed count
	wire [POS_W-1:0] pos_up  = pos_reg + POS_W'(1);
	wire [POS_W-1:0] pos_dn  = pos_reg - POS_W'(1);
	wire [15:0]      cnt_inc = count_reg + 16'(accept);

	assign pos_next = accept ? (ev_ccw ? pos_dn : pos_up) : pos_reg;

	// ************************************************************
	// Pulse-width monitor
	// ************************************************************

	// Short active pulses on the step input are flagged for software, not rejected, so a marginal
	// controller still moves the motor while the fault stays visible
	wire       step_active = edge_fall ? ~step_lvl : step_lvl;
	wire       step_end    = edge_fall ? step_rise : step_fall;
	wire       short_seen  = step_end & (high_cnt_reg < 8'(PULSE_MIN_CYC));
	wire [7:0] high_cnt_up = (high_cnt_reg == 8'hff) ? 8'hff : high_cnt_reg + 8'h01;

	// ************************************************************
	// APB slave
	// ************************************************************
	wire        apb_wr   = psel & penable & pwrite;
	wire        sel_ctrl = paddr == SDCI_CTRL_OFS;
	wire        sel_st   = paddr == SDCI_STATUS_OFS;
	wire        sel_pos  = paddr == SDCI_POS_OFS;
	wire        sel_cnt  = paddr == SDCI_COUNT_OFS;
	wire        mapped   = sel_ctrl | sel_st | sel_pos | sel_cnt;
	wire        clr_pos  = apb_wr & sel_ctrl & pwdata[SDCI_CTRL_CLR_BIT];
	wire        clr_flag = apb_wr & sel_st & pwdata[SDCI_ST_STEP_BIT];
	wire [31:0] status_w = {28'h0, short_pulse_reg, 1'b0, dir_lvl, en_lvl};
	wire [31:0] rd_mux   = sel_ctrl ? {29'h0, 1'b0, ctrl_reg[1:0]} :
	                       sel_st   ? status_w :
	                       sel_pos  ? pos_reg :
	                       sel_cnt  ? {16'h0, count_reg} : 32'h0;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= SDCI_CTRL_RESET;
		end else if (apb_wr & sel_ctrl) begin
			ctrl_reg <= {30'h0, pwdata[SDCI_CTRL_EDGE_BIT], pwdata[SDCI_CTRL_MODE_BIT]};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pos_reg   <= '0;
			count_reg <= 16'h0000;
		end else begin
			pos_reg   <= clr_pos ? '0 : pos_next;
			count_reg <= clr_pos ? 16'h0000 : cnt_inc;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			high_cnt_reg    <= 8'h00;
			short_pulse_reg <= 1'b0;
		end else begin
			high_cnt_reg    <= step_active ? high_cnt_up : 8'h00;
			// Set wins over clear
			short_pulse_reg <= short_seen | (short_pulse_reg & ~clr_flag);
		end
	end

	// ************************************************************
	// APB response
	// ************************************************************

	// Zero wait states: the answer is registered off the setup cycle
	wire        setup_ph = psel & ~penable;
	wire        rd_setup = setup_ph & ~pwrite;
	wire [31:0] rd_next  = rd_setup ? rd_mux : 32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_ph;
			pslverr <= setup_ph & ~mapped;
			prdata  <= rd_next;
		end
	end

	// ************************************************************
	// Step and enable outputs
	// ************************************************************

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			step_advance_reg <= 1'b0;
			step_dir_ccw_reg <= 1'b0;
		end else begin
			step_advance_reg <= accept;
			step_dir_ccw_reg <= accept ? ev_ccw : step_dir_ccw_reg;
		end
	end

	// Enable is reported one cycle after the level that gates steps
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_enabled_reg <= 1'b0;
		end else begin
			drive_enabled_reg <= en_lvl;
		end
	end

	assign step_advance  = step_advance_reg;
	assign step_dir_ccw  = step_dir_ccw_reg;
	assign drive_enabled = drive_enabled_reg;
endmodule

/* File: testbench/sdci_sva.sv */
// Port checker for the command input block
`timescale 1ns/1ps
module sdci_sva (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        step_pulse_in,
	input wire logic        dir_in,
	input wire logic        drive_enable_in,
	input wire logic        step_advance,
	input wire logic        step_dir_ccw,
	input wire logic        drive_enabled
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_ready_next: assert property (psel && !penable |=> pready) else $error("no ready");
	a_ready_once: assert property (pready |=> !pready) else $error("ready held");
	a_err_addr: assert property (psel && !penable && paddr[11:4] != 8'h00 |=> pslverr) else $error("no error");
	a_adv_pulse: assert property (step_advance |=> !step_advance) else $error("advance held");
	a_adv_cause: assert property (step_advance |->
		$past(step_pulse_in, 2) != $past(step_pulse_in, 7) || $past(dir_in, 2) != $past(dir_in, 7))
		else $error("advance without pin edge");
	a_dis_quiet: assert property (!drive_enabled [*3] |-> !step_advance) else $error("step disabled");
	a_en_follow: assert property ($stable(drive_enable_in) [*5] |-> drive_enabled == drive_enable_in)
		else $error("enable not followed");
	a_dir_hold: assert property ($changed(step_dir_ccw) |-> step_advance) else $error("direction moved");
	c_step: cover property (step_advance);
	c_ccw: cover property (step_advance && step_dir_ccw);
	c_err: cover property (pslverr);
endmodule
bind sdci_top sdci_sva chk_u (.*);

/* File: testbench/sdci_ctrl_model.sv */
// Behavioural motion controller on the command pins
`timescale 1ns/1ps
module sdci_ctrl_model (
	input  wire logic pclk,
	output logic      step_pulse_in,
	output logic      dir_in,
	output logic      drive_enable_in
);
	logic en_drv = 1'b0;
	logic en_open = 1'b1;
	initial {step_pulse_in, dir_in} = 2'b00;
	// Open enable pin is pulled up
	assign drive_enable_in = en_open | en_drv;
	// Each level holds 80 cycles: above the minimum width, low time and period
	task automatic put(logic s, logic d);
		{step_pulse_in, dir_in} <= {s, d};
		repeat (80) @(posedge pclk);
	endtask
	// Enable settles well before the next direction change
	task automatic enable(logic o, logic v);
		{en_open, en_drv} <= {o, v};
		repeat (60) @(posedge pclk);
	endtask
endmodule

/* File: testbench/sdci_tb_top.sv */
// Self-checking bench of the command input block
`timescale 1ns/1ps
module sdci_tb_top;
	import sdci_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd, p;
	logic        pready, pslverr, err, step_advance, step_dir_ccw, drive_enabled;
	logic        step_pulse_in, dir_in, drive_enable_in;
	int          mismatches = 0, cmp_count = 0, n_adv = 0;
	always #50 pclk = ~pclk;
	always @(posedge pclk) if (step_advance === 1'b1) n_adv <= n_adv + 1;
	sdci_top dut_u (.*);
	sdci_ctrl_model ctl_u (.*);
	task automatic chk(string s, logic [31:0] e, logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("CHECK FAILED %s exp %h got %h", s, e, g);
		end
	endtask
	task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		err = pslverr;
		{psel, penable} <= 2'b00;
		@(posedge pclk);
	endtask
	task automatic t_edges;
		logic k;
		apb(1'b0, SDCI_CTRL_OFS, 32'h0);
		chk("ctrl", SDCI_CTRL_RESET, rd);
		ctl_u.put(1'b1, 1'b0);
		k = step_dir_ccw;
		ctl_u.put(1'b0, 1'b1);
		ctl_u.put(1'b1, 1'b1);
		chk("dir", {31'h0, ~k}, {31'h0, step_dir_ccw});
		apb(1'b1, SDCI_CTRL_OFS, 32'h2);
		ctl_u.put(1'b0, 1'b1);
		chk("steps", 32'h3, n_adv);
		$display("edge test done");
	endtask
	task automatic t_dual;
		apb(1'b1, SDCI_CTRL_OFS, 32'h1);
		apb(1'b0, SDCI_POS_OFS, 32'h0);
		p = rd;
		ctl_u.put(1'b1, 1'b0);
		ctl_u.put(1'b0, 1'b0);
		apb(1'b0, SDCI_POS_OFS, 32'h0);
		chk("cw", p + 32'h1, rd);
		ctl_u.put(1'b0, 1'b1);
		apb(1'b0, SDCI_POS_OFS, 32'h0);
		chk("ccw", p, rd);
		chk("ccw dir", 32'h1, 32'(step_dir_ccw));
		apb(1'b1, SDCI_CTRL_OFS, 32'h3);
		ctl_u.put(1'b1, 1'b0);
		apb(1'b0, SDCI_POS_OFS, 32'h0);
		chk("ccw fall", p - 32'h1, rd);
		$display("dual pulse test done");
	endtask
	task automatic t_disable;
		ctl_u.enable(1'b0, 1'b0);
		chk("off", 32'h0, 32'(drive_enabled));
		ctl_u.put(1'b1, 1'b0);
		ctl_u.put(1'b0, 1'b0);
		chk("ignored", 32'h6, n_adv);
		apb(1'b0, SDCI_COUNT_OFS, 32'h0);
		chk("count", 32'h6, rd);
		ctl_u.enable(1'b1, 1'b0);
		chk("open", 32'h1, 32'(drive_enabled));
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 32'h1, 32'(err));
		apb(1'b1, SDCI_CTRL_OFS, 32'h4);
		apb(1'b0, SDCI_POS_OFS, 32'h0);
		chk("cleared", 32'h0, rd);
		$display("enable test done");
	endtask
	task automatic wrap_up(int extra);
		mismatches += extra;
		$display("Compared %0d, mismatched %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// Whole run is near 960 cycles; a hang ends here
	initial #500_000 wrap_up(1);
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		t_edges;
		t_dual;
		t_disable;
		wrap_up(0);
	end
endmodule
